// *** core/hpi_pkg.sv ***
// Constants and types shared by the host processor port
package hpi_pkg;
    localparam logic [8:0] HPI_OFS_IO_CONTROL = 9'h1ec;
    localparam logic [8:0] HPI_OFS_BLIND_STATUS = 9'h1f0;
    localparam int HPI_BIT_BYTE_WIDTH = 0;
    localparam int HPI_BIT_BIG_ENDIAN = 1;
    localparam int HPI_BIT_INT_POL = 2;
    localparam int HPI_BIT_ACK_PUSHPULL = 3;
    localparam int HPI_BIT_INT_PUSHPULL = 4;
    localparam int HPI_BIT_BLIND = 5;
    localparam int HPI_BIT_DATA_INVAR = 6;
    localparam int HPI_BIT_ACK_POL = 7;
    localparam logic [31:0] HPI_IO_CONTROL_RST = 32'h0000_0000;
    localparam logic [31:0] HPI_IO_CONTROL_MASK = 32'h0000_00ff;
    localparam int HPI_SETTLE_CLKS = 4;
    localparam int HPI_READ_LATENCY_MAX = 19;
    localparam logic [4:0] HPI_READ_LATENCY_CNT = 5'(HPI_READ_LATENCY_MAX);

    typedef enum logic [1:0]
    {
        HPI_STYLE_SYNC = 2'b00,
        HPI_STYLE_ASYNC16 = 2'b01,
        HPI_STYLE_MCU8 = 2'b10,
        HPI_STYLE_RSVD = 2'b11
    } hpi_style_t;

    typedef enum logic [1:0]
    {
        HPI_ST_IDLE = 2'b00,
        HPI_ST_RD_WAIT = 2'b01,
        HPI_ST_WR_WAIT = 2'b10,
        HPI_ST_DONE = 2'b11
    } hpi_state_t;
endpackage

// *** core/hpi_reg_if.sv ***
// Internal register access path between port and register space
`timescale 1ns/10ps
`default_nettype none
interface hpi_reg_if;
    logic req;
    logic we;
    logic [8:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic ack;
    modport port (output req, output we, output addr, output wdata, input rdata, input ack);
    modport regs (input req, input we, input addr, input wdata, output rdata, output ack);
endinterface
`default_nettype wire

// *** core/hpi_regs.sv ***
// Configuration register space reached through the port
`timescale 1ns/10ps
`default_nettype none
module hpi_regs
    import hpi_pkg::*;
#(
    parameter int DEPTH = 128
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Request side
    hpi_reg_if.regs bus
);
    logic [31:0] mem [DEPTH];
    logic [31:0] rdata_ff;
    logic ack_ff;
    wire [6:0] idx = bus.addr[8:2];

    always_ff @(posedge i_clk)
    begin
        if (bus.req && bus.we)
            mem[idx] <= bus.wdata;
        rdata_ff <= mem[idx];
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ack_ff <= 1'b0;
        else
            ack_ff <= bus.req && !ack_ff;
    end

    assign bus.rdata = rdata_ff;
    assign bus.ack = ack_ff;
endmodule
`default_nettype wire

// *** core/hpi_port.sv ***
// Host processor port: style decode, quadlet stacking, I/O control
// What this block does
// - Two strap inputs select host style: 11 reserved, 10 byte MCU, 01 async, 00 sync.
// - Control pins remap by style; strobes in MCU style, ack unused there.
// - MCU style uses the low-byte data lines as muxed address/data with strobes.
// - Sync style uses host bus clock; other styles also sample host signals directly on it, with no synchroniser.
// - Host bus bit0 is MSB on address and data; LSB is bit8 on address, bit15 on data.
// - Host transfers stack into 32-bit quadlets with endian byte swap.
// - A 32-bit I/O control register at byte offset 1ECh holds options.
// - Bit 0 selects byte access when set, word access when clear.
// - Bit 1 big endian; bit 6 data invariant, ignored in big endian.
// - Bit 2 makes the interrupt output active high when set.
// - Bit 3 drives ack push/pull when set, else open drain (low driven, high released); no pulls.
// - Bit 4 drives interrupt push/pull when set, else open drain (low driven, high released).
// - Bit 7 makes ack active high; bit 5 enables blind access mode.
// - In MCU style the ack push/pull bit always reads as zero.
// - Every transaction starts with chip select, address and direction.
// - In handshake mode the device asserts acknowledge to end a transaction.
// - In blind mode the host polls the status register at 1F0h.
// - New-quadlet read fetches within 19 clocks; later reads use the buffer.
// - Internal write starts only when the buffer holds a full quadlet.
// - Partial write broken by other access is discarded and flagged.
`timescale 1ns/10ps
`default_nettype none
module hpi_port
    import hpi_pkg::*;
#(
    parameter int REG_DEPTH = 128
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Style straps
    input wire logic i_host_type_select_hi,
    input wire logic i_host_type_select_lo,
    // Host bus, bit0 is MSB
    input wire logic [0:8] i_addr,
    input wire logic [0:15] i_data,
    output logic [0:15] o_data,
    output logic [0:15] o_data_oe_n,
    input wire logic i_chip_select_n,
    input wire logic i_host_control_pin_a,
    input wire logic i_host_control_pin_b,
    // Acknowledge pin
    output logic o_ack,
    output logic o_ack_oe_n,
    // Interrupt pin
    input wire logic i_event,
    output logic o_int,
    output logic o_int_oe_n,
    // Status
    output logic o_invalid_write_flag,
    output logic o_unsupported
);
    hpi_reg_if rif();
    hpi_regs #(.DEPTH(REG_DEPTH)) u_regs (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(rif.regs));

    hpi_style_t style_ff;
    hpi_state_t state_ff, nxt_state;
    logic [31:0] ctrl_ff;
    logic [31:0] buf_ff;
    logic [3:0] wr_mask_ff, rd_mask_ff;
    logic [8:0] qaddr_ff;
    logic rd_valid_ff, wr_open_ff;
    logic cs_d_ff, strobe_d_ff;
    logic [8:0] mcu_addr_ff;
    logic ack_ff, inv_ff;
    logic [4:0] lat_ff;
    logic [15:0] dout_ff;
    logic drive_ff;
    logic [2:0] settle_ff;
    logic strap_seen_ff;

    // Styles
    wire is_mcu = (style_ff == HPI_STYLE_MCU8);
    wire is_rsvd = (style_ff == HPI_STYLE_RSVD);
    wire byte_mode = ctrl_ff[HPI_BIT_BYTE_WIDTH];
    wire big_end = ctrl_ff[HPI_BIT_BIG_ENDIAN];
    wire data_inv = ctrl_ff[HPI_BIT_DATA_INVAR] && !big_end;
    wire blind = ctrl_ff[HPI_BIT_BLIND];

    // Pin remapping; bit-reversed buses give natural LSB-zero vectors
    wire [15:0] din;
    wire [8:0] ain;
    genvar g;
    generate
        for (g = 0; g < 16; g++)
        begin : g_data
            assign din[g] = i_data[15 - g];
            assign o_data[15 - g] = dout_ff[g];
            assign o_data_oe_n[15 - g] = !(drive_ff && (!is_mcu || g < 8));
        end
        for (g = 0; g < 9; g++)
        begin : g_addr
            assign ain[g] = i_addr[8 - g];
        end
    endgenerate

    // MCU: low byte of data carries AD, data line 7 carries A0, ADR1 is ALE
    wire ale = i_addr[1];
    wire rd_strobe = is_mcu ? !i_host_control_pin_b : i_host_control_pin_a;
    wire wr_strobe = is_mcu ? !i_host_control_pin_a : !i_host_control_pin_a;
    wire strobe = is_mcu ? (rd_strobe || wr_strobe) : 1'b1;
    wire cs = !i_chip_select_n && !is_rsvd;
    wire [8:0] eff_addr = is_mcu ? {i_data[7], mcu_addr_ff[7:0]} : ain;
    wire is_read = is_mcu ? rd_strobe : i_host_control_pin_a;
    // No new access is taken while a control update settles
    wire start = (is_mcu ? (cs && strobe && !strobe_d_ff) : (cs && !cs_d_ff)) && (settle_ff == 3'd0);
    wire [8:0] quad = {eff_addr[8:2], 2'b00};
    wire [1:0] lane = byte_mode ? eff_addr[1:0] : {eff_addr[1], 1'b0};
    wire [3:0] sel = byte_mode ? (4'b0001 << lane) : (4'b0011 << lane);
    wire [15:0] wr_val = is_mcu ? {8'h00, din[7:0]} : din;

    // Byte position after endian handling
    wire swap = big_end || !data_inv;
    wire [1:0] phys = swap ? (2'd3 - lane) : lane;
    wire [31:0] placed = byte_mode ? ({24'h0, wr_val[7:0]} << {phys, 3'b000})
        : ({16'h0, wr_val} << {phys[1], 4'b0000});
    wire [3:0] phys_sel = byte_mode ? (4'b0001 << phys) : (4'b0011 << {phys[1], 1'b0});
    wire [31:0] lane_mask = {{8{phys_sel[3]}}, {8{phys_sel[2]}}, {8{phys_sel[1]}}, {8{phys_sel[0]}}};
    wire [31:0] rd_shift = buf_ff >> (byte_mode ? {phys, 3'b000} : {phys[1], 4'b0000});
    wire [15:0] rd_val = byte_mode ? {8'h00, rd_shift[7:0]} : rd_shift[15:0];

    wire same_q = (quad == qaddr_ff);
    wire rd_hit = rd_valid_ff && same_q && ((rd_mask_ff & sel) == 4'b0000);
    wire wr_bad = wr_open_ff && (is_read || !same_q || ((wr_mask_ff & sel) != 4'b0000));
    wire [3:0] new_mask = (wr_open_ff && !wr_bad ? wr_mask_ff : 4'b0000) | sel;
    wire wr_full = (new_mask == 4'b1111);
    // The status fetch itself is not counted as pending work
    wire blind_done = (state_ff != HPI_ST_WR_WAIT) && !ack_ff;

    // Sequencing
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            HPI_ST_IDLE:
                if (start && is_read && !rd_hit)
                    nxt_state = HPI_ST_RD_WAIT;
                else if (start && !is_read && wr_full)
                    nxt_state = HPI_ST_WR_WAIT;
                else if (start)
                    nxt_state = HPI_ST_DONE;
            HPI_ST_RD_WAIT, HPI_ST_WR_WAIT:
                if (rif.ack || lat_ff == HPI_READ_LATENCY_CNT)
                    nxt_state = HPI_ST_DONE;
            HPI_ST_DONE:
                if (!cs || blind)
                    nxt_state = HPI_ST_IDLE;
        endcase
    end

    // Internal register requests; control and status answered locally
    wire ctrl_hit = (qaddr_ff == HPI_OFS_IO_CONTROL);
    wire stat_hit = (qaddr_ff == HPI_OFS_BLIND_STATUS);
    assign rif.req = (state_ff != HPI_ST_IDLE) && (state_ff != HPI_ST_DONE) && lat_ff == 5'd0;
    assign rif.we = (state_ff == HPI_ST_WR_WAIT);
    assign rif.addr = qaddr_ff;
    assign rif.wdata = buf_ff;
    wire [31:0] ctrl_rd = {ctrl_ff[31:4], ctrl_ff[3] && !is_mcu, ctrl_ff[2:0]};
    wire [31:0] fetched = ctrl_hit ? ctrl_rd : stat_hit ? {31'h0, blind_done} : rif.rdata;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            style_ff <= HPI_STYLE_RSVD;
            strap_seen_ff <= 1'b0;
            state_ff <= HPI_ST_IDLE;
            cs_d_ff <= 1'b0;
            strobe_d_ff <= 1'b0;
            mcu_addr_ff <= 9'h000;
            lat_ff <= 5'd0;
        end
        else
        begin
            // Straps caught once after reset release
            strap_seen_ff <= 1'b1;
            if (!strap_seen_ff)
                style_ff <= hpi_style_t'({i_host_type_select_hi, i_host_type_select_lo});
            state_ff <= nxt_state;
            // Host pins taken as synchronous to the port clock in every style
            cs_d_ff <= cs;
            strobe_d_ff <= strobe;
            if (is_mcu && ale)
                mcu_addr_ff <= {1'b0, din[7:0]};
            lat_ff <= (state_ff == HPI_ST_RD_WAIT || state_ff == HPI_ST_WR_WAIT) ? lat_ff + 5'd1 : 5'd0;
        end
    end

    // Stacking buffer
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            buf_ff <= 32'h0;
            qaddr_ff <= 9'h000;
            wr_mask_ff <= 4'b0000;
            rd_mask_ff <= 4'b0000;
            rd_valid_ff <= 1'b0;
            wr_open_ff <= 1'b0;
            inv_ff <= 1'b0;
            ctrl_ff <= HPI_IO_CONTROL_RST;
            dout_ff <= 16'h0000;
        end
        else
        begin
            // Sticky until reset; a read breaks a partial write too
            if (start && state_ff == HPI_ST_IDLE && wr_bad)
                inv_ff <= 1'b1;
            if (start && state_ff == HPI_ST_IDLE)
            begin
                if (is_read)
                begin
                    wr_open_ff <= 1'b0;
                    qaddr_ff <= quad;
                    if (rd_hit)
                    begin
                        rd_mask_ff <= rd_mask_ff | sel;
                        dout_ff <= rd_val;
                    end
                    else
                    begin
                        rd_valid_ff <= 1'b0;
                        rd_mask_ff <= sel;
                    end
                end
                else
                begin
                    rd_valid_ff <= 1'b0;
                    qaddr_ff <= quad;
                    wr_mask_ff <= wr_full ? 4'b0000 : new_mask;
                    wr_open_ff <= !wr_full;
                    buf_ff <= ((wr_open_ff && !wr_bad) ? (buf_ff & ~lane_mask) : 32'h0) | (placed & lane_mask);
                end
            end
            if (state_ff == HPI_ST_RD_WAIT && nxt_state == HPI_ST_DONE)
            begin
                buf_ff <= fetched;
                rd_valid_ff <= 1'b1;
                dout_ff <= byte_mode ? {8'h00, fetched[{phys, 3'b000} +: 8]}
                    : fetched[{phys[1], 4'b0000} +: 16];
            end
            if (state_ff == HPI_ST_WR_WAIT && nxt_state == HPI_ST_DONE && ctrl_hit)
                ctrl_ff <= buf_ff & HPI_IO_CONTROL_MASK;
        end
    end

    // Pin drivers: acknowledge, data, interrupt
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ack_ff <= 1'b0;
            drive_ff <= 1'b0;
            settle_ff <= 3'd0;
        end
        else
        begin
            ack_ff <= (nxt_state == HPI_ST_DONE) && cs && !blind && !is_mcu;
            drive_ff <= cs && is_read && (nxt_state == HPI_ST_DONE || state_ff == HPI_ST_DONE);
            // Settling window after a control update; host keeps idle
            settle_ff <= (state_ff == HPI_ST_WR_WAIT && ctrl_hit) ? 3'(HPI_SETTLE_CLKS) :
                (settle_ff != 3'd0 ? settle_ff - 3'd1 : 3'd0);
        end
    end

    wire ack_pp = ctrl_ff[HPI_BIT_ACK_PUSHPULL];
    wire ack_lvl = ack_ff ~^ ctrl_ff[HPI_BIT_ACK_POL];
    assign o_ack = ack_pp ? ack_lvl : 1'b0;
    assign o_ack_oe_n = is_mcu || !(ack_pp || !ack_lvl);
    wire int_pp = ctrl_ff[HPI_BIT_INT_PUSHPULL];
    wire int_lvl = i_event ~^ ctrl_ff[HPI_BIT_INT_POL];
    assign o_int = int_pp ? int_lvl : 1'b0;
    assign o_int_oe_n = !(int_pp || !int_lvl);
    assign o_invalid_write_flag = inv_ff;
    assign o_unsupported = is_rsvd;
endmodule
`default_nettype wire

// *** dv/hpi_port_monitor.sv ***
// Port-level assertions for the host processor port
`timescale 1ns/10ps
`default_nettype none
module hpi_port_monitor
(
    // Clock, reset and straps
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_host_type_select_hi,
    input wire logic i_host_type_select_lo,
    // Observed host pins
    input wire logic i_chip_select_n,
    input wire logic i_host_control_pin_a,
    input wire logic i_event,
    input wire logic [0:15] o_data_oe_n,
    input wire logic o_ack_oe_n,
    input wire logic o_int,
    input wire logic o_int_oe_n,
    input wire logic o_invalid_write_flag,
    input wire logic o_unsupported
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    property p_rsvd_inert;
        i_host_type_select_hi && i_host_type_select_lo |-> o_unsupported && (&o_data_oe_n) && o_ack_oe_n;
    endproperty
    a_rsvd_inert: assert property (p_rsvd_inert) else $error("reserved style drives pins");
    property p_style_latched;
        !$rose(o_unsupported);
    endproperty
    a_style_latched: assert property (p_style_latched) else $error("style changed outside reset");
    property p_mcu_no_ack;
        i_host_type_select_hi && !i_host_type_select_lo |-> o_ack_oe_n;
    endproperty
    a_mcu_no_ack: assert property (p_mcu_no_ack) else $error("ack driven in byte MCU style");
    property p_read_latency;
        $fell(i_chip_select_n) && i_host_control_pin_a && !o_unsupported && !(i_host_type_select_hi && !i_host_type_select_lo)
            |-> ##[1:21] !(&o_data_oe_n);
    endproperty
    a_read_latency: assert property (p_read_latency) else $error("read data late");
    property p_idle_released;
        i_chip_select_n && $past(i_chip_select_n) |-> &o_data_oe_n;
    endproperty
    a_idle_released: assert property (p_idle_released) else $error("data driven while deselected");
    property p_write_released;
        !i_chip_select_n && !i_host_control_pin_a && !$past(i_host_control_pin_a) |-> &o_data_oe_n;
    endproperty
    a_write_released: assert property (p_write_released) else $error("data driven during write");
    property p_data_stands;
        !i_chip_select_n && !(&o_data_oe_n) |=> i_chip_select_n || !(&o_data_oe_n);
    endproperty
    a_data_stands: assert property (p_data_stands) else $error("read data dropped early");
    property p_flag_sticky;
        o_invalid_write_flag |=> o_invalid_write_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("invalid write flag lost");
    property p_int_steady;
        (i_chip_select_n && $stable(i_event)) [*6] |-> $stable(o_int) && $stable(o_int_oe_n);
    endproperty
    a_int_steady: assert property (p_int_steady) else $error("interrupt pin moved alone");
endmodule
bind hpi_port hpi_port_monitor mon (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_host_type_select_hi(i_host_type_select_hi), .i_host_type_select_lo(i_host_type_select_lo),
    .i_chip_select_n(i_chip_select_n), .i_host_control_pin_a(i_host_control_pin_a), .i_event(i_event),
    .o_data_oe_n(o_data_oe_n), .o_ack_oe_n(o_ack_oe_n), .o_int(o_int), .o_int_oe_n(o_int_oe_n),
    .o_invalid_write_flag(o_invalid_write_flag), .o_unsupported(o_unsupported));
`default_nettype wire

// *** dv/hpi_host_model.sv ***
// Host bus master model for the port's word-wide styles
`timescale 1ns/10ps
`default_nettype none
module hpi_host_model
(
    // Clock
    input wire logic i_clk,
    // From the port
    input wire logic [0:15] i_data,
    input wire logic i_ack,
    input wire logic i_ack_oe_n,
    // To the port
    output logic [0:8] o_addr,
    output logic [0:15] o_data,
    output logic o_chip_select_n,
    output logic o_host_control_pin_a,
    output logic o_host_control_pin_b
);
    // No pull inside the port, so a board pull-up is assumed
    wire logic ack_wire = i_ack_oe_n ? 1'b1 : i_ack;
    initial
    begin
        o_addr = 9'h000;
        o_data = 16'h0000;
        o_chip_select_n = 1'b1;
        o_host_control_pin_a = 1'b1;
        o_host_control_pin_b = 1'b1;
    end
    // Word access in handshake mode only, ack low true
    task automatic xfer(input logic we, input logic [8:0] a, input logic [15:0] wd, output logic [15:0] rd,
        output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        rd = 16'h0000;
        @(negedge i_clk);
        o_addr = a;
        o_data = wd;
        o_host_control_pin_a = !we;
        o_chip_select_n = 1'b0;
        while (!ok && n < 30)
        begin
            @(posedge i_clk);
            n++;
            if (ack_wire === 1'b0)
            begin
                ok = 1'b1;
                rd = i_data;
            end
        end
        @(negedge i_clk);
        o_chip_select_n = 1'b1;
        o_addr = ~o_addr;
        o_data = ~o_data;
        // Extra idle lets the port sample chip select released before the next start
        repeat (2) @(negedge i_clk);
    endtask
endmodule
`default_nettype wire

// *** dv/hpi_port_bench.sv ***
// Self-checking bench for the host processor port
`timescale 1ns/10ps
`default_nettype none
module hpi_port_bench
    import hpi_pkg::*;
;
    logic i_clk;
    logic i_rst_n = 1'b0;
    logic sel_hi = 1'b0;
    logic sel_lo = 1'b0;
    logic i_event = 1'b0;
    wire logic [0:8] addr;
    wire logic [0:15] h_data;
    wire logic [0:15] o_data;
    wire logic [0:15] o_data_oe_n;
    wire logic cs_n, pin_a, pin_b, o_ack, o_ack_oe_n, o_int, o_int_oe_n, o_inv, o_uns;
    wire logic [0:15] d_wire = (o_data & ~o_data_oe_n) | (h_data & o_data_oe_n);
    int n_errors = 0;
    int compares = 0;
    hpi_host_model host (.i_clk(i_clk), .i_data(d_wire), .i_ack(o_ack), .i_ack_oe_n(o_ack_oe_n), .o_addr(addr),
        .o_data(h_data), .o_chip_select_n(cs_n), .o_host_control_pin_a(pin_a), .o_host_control_pin_b(pin_b));
    hpi_port #(.REG_DEPTH(128)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_host_type_select_hi(sel_hi),
        .i_host_type_select_lo(sel_lo), .i_addr(addr), .i_data(d_wire), .o_data(o_data), .o_data_oe_n(o_data_oe_n),
        .i_chip_select_n(cs_n), .i_host_control_pin_a(pin_a), .i_host_control_pin_b(pin_b), .o_ack(o_ack),
        .o_ack_oe_n(o_ack_oe_n), .i_event(i_event), .o_int(o_int), .o_int_oe_n(o_int_oe_n),
        .o_invalid_write_flag(o_inv), .o_unsupported(o_uns));
    initial
    begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    task automatic results();
        if (n_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            $display("FAIL %s expected %h seen %h", what, exp, seen);
            n_errors++;
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        logic [15:0] v;
        logic ok;
        host.xfer(1'b1, a, d, v, ok);
        check("write ack", 16'(ok), 16'h0001);
    endtask
    task automatic rd(input logic [8:0] a, input logic [15:0] exp);
        logic [15:0] v;
        logic ok;
        host.xfer(1'b0, a, 16'h0000, v, ok);
        check("read ack", 16'(ok), 16'h0001);
        check("read data", v, exp);
    endtask
    task automatic do_reset(input logic [1:0] s);
        @(negedge i_clk);
        i_rst_n = 1'b0;
        sel_hi = s[1];
        sel_lo = s[0];
        repeat (2) @(negedge i_clk);
        i_rst_n = 1'b1;
        repeat (2) @(negedge i_clk);
    endtask
    task automatic int_chk(input logic ev, input logic ei, input logic eo);
        @(negedge i_clk);
        i_event = ev;
        repeat (3) @(negedge i_clk);
        check("int level", 16'(o_int), 16'(ei));
        check("int oe_n", 16'(o_int_oe_n), 16'(eo));
    endtask
    initial
    begin
        repeat (20000) @(posedge i_clk);
        n_errors++;
        results();
    end
    initial
    begin
        logic [15:0] v;
        logic ok;
        // Async style first, then the synchronous style stays up
        for (int s = 1; s >= 0; s--)
        begin
            do_reset(2'(s));
            wr(HPI_OFS_IO_CONTROL, 16'h0000);
            wr(HPI_OFS_IO_CONTROL + 9'h002, 16'h0000);
            repeat (HPI_SETTLE_CLKS) @(negedge i_clk);
            rd(HPI_OFS_IO_CONTROL, 16'h0000);
            rd(HPI_OFS_IO_CONTROL + 9'h002, 16'h0000);
            wr(9'h040, 16'hc3a5);
            wr(9'h042, 16'h5a3c);
            rd(9'h042, 16'h5a3c);
            rd(9'h040, 16'hc3a5);
        end
        int_chk(1'b1, 1'b0, 1'b0);
        int_chk(1'b0, 1'b0, 1'b1);
        host.xfer(1'b0, HPI_OFS_BLIND_STATUS + 9'h002, 16'h0000, v, ok);
        check("blind idle", 16'(v[0]), 16'h0001);
        wr(9'h010, 16'h1234);
        wr(9'h012, 16'h5678);
        check("flag clear", 16'(o_inv), 16'h0000);
        wr(9'h020, 16'haaaa);
        wr(9'h030, 16'hbbbb);
        check("flag set", 16'(o_inv), 16'h0001);
        wr(9'h032, 16'hcccc);
        // Big endian with bit 6 set, int high push/pull, ack push/pull; ack polarity kept to avoid a mid-cycle flip
        wr(HPI_OFS_IO_CONTROL, 16'h0000);
        wr(HPI_OFS_IO_CONTROL + 9'h002, 16'h005e);
        repeat (HPI_SETTLE_CLKS) @(negedge i_clk);
        check("ack oe_n", 16'(o_ack_oe_n), 16'h0000);
        check("ack idle", 16'(o_ack), 16'h0001);
        rd(HPI_OFS_IO_CONTROL, 16'h0000);
        rd(HPI_OFS_IO_CONTROL + 9'h002, 16'h005e);
        // Bit 6 ignored in big endian: same lanes as the default
        rd(9'h010, 16'h1234);
        rd(9'h012, 16'h5678);
        int_chk(1'b1, 1'b1, 1'b0);
        int_chk(1'b0, 1'b0, 1'b0);
        // Little endian, data invariant, byte access
        wr(HPI_OFS_IO_CONTROL, 16'h0000);
        wr(HPI_OFS_IO_CONTROL + 9'h002, 16'h005d);
        repeat (HPI_SETTLE_CLKS) @(negedge i_clk);
        wr(9'h050, 16'h0011);
        wr(9'h051, 16'h0022);
        wr(9'h052, 16'h0033);
        wr(9'h053, 16'h0044);
        rd(9'h052, 16'h0033);
        rd(9'h050, 16'h0011);
        rd(9'h010, 16'h0078);
        // Byte-wide control update: setting in the first byte, zeros after
        wr(HPI_OFS_IO_CONTROL, 16'h005c);
        wr(HPI_OFS_IO_CONTROL + 9'h001, 16'h0000);
        wr(HPI_OFS_IO_CONTROL + 9'h002, 16'h0000);
        wr(HPI_OFS_IO_CONTROL + 9'h003, 16'h0000);
        repeat (HPI_SETTLE_CLKS) @(negedge i_clk);
        rd(HPI_OFS_IO_CONTROL, 16'h005c);
        // A read breaks an open partial write
        do_reset(2'b01);
        check("flag reset", 16'(o_inv), 16'h0000);
        wr(9'h020, 16'haaaa);
        rd(9'h040, 16'hc3a5);
        check("flag read", 16'(o_inv), 16'h0001);
        do_reset(2'b10);
        check("mcu supported", 16'(o_uns), 16'h0000);
        check("mcu ack oe_n", 16'(o_ack_oe_n), 16'h0001);
        do_reset(2'b11);
        check("rsvd flag", 16'(o_uns), 16'h0001);
        host.xfer(1'b0, 9'h010, 16'h0000, v, ok);
        check("rsvd ack", 16'(ok), 16'h0000);
        results();
    end
endmodule
`default_nettype wire
